// *** dsl_regs.svh ***
/*
 * Offsets, field positions, reset values and timing counts for the drive
 * status lamp driver. Assumes a 100 MHz mclk and 32-bit APB.
 */
`ifndef DSL_REGS_SVH
`define DSL_REGS_SVH

// Register byte addresses
`define DSL_STATUS_ADDR   12'h000
`define DSL_CONTROL_ADDR  12'h004
`define DSL_IRQ_STAT_ADDR 12'h008
`define DSL_IRQ_MASK_ADDR 12'h00C
`define DSL_ALIAS_ADDR    12'h010
`define DSL_LAMPS_ADDR    12'h014

// Control fields
`define DSL_CTL_SW_ALIAS_BIT 0
`define DSL_CTL_TEST_BIT     1
`define DSL_CONTROL_RESET    32'h0000_0000
`define DSL_ALIAS_RESET      16'h0000
`define DSL_MASK_RESET       8'h00
// Event history at reset: supply-lost reads high while the inputs are flushed
`define DSL_EV_PREV_RESET    8'h20

// Status change flag value that marks a change/error
`define DSL_AL_CHANGE_ERR    8'h01

// Timing
`define DSL_CLK_HZ        100000000
`define DSL_TICK_MS       1
`define DSL_TICK_CYC      ((`DSL_CLK_HZ / 1000) * `DSL_TICK_MS)
`define DSL_FLASH_MS      200
`define DSL_LONG_OFF_MS   1000
`define DSL_FLICKER_MS    50

`endif

// *** dsl_pkg.sv ***
/*
 * Types for the drive status lamp driver.
 * Assumes dsl_regs.svh holds every number.
 */
package dsl_pkg;

	// Fieldbus slave state as reported by the network controller
	typedef enum logic [2:0] {
		DSL_FB_BOOT,
		DSL_FB_INIT,
		DSL_FB_PREOP,
		DSL_FB_BOOTSTRAP,
		DSL_FB_SAFEOP,
		DSL_FB_OP
	} dsl_fb_state_t;

	// Lamp pattern selectors
	typedef enum logic [2:0] {
		DSL_PAT_OFF,
		DSL_PAT_ON,
		DSL_PAT_BLINK,
		DSL_PAT_FLICKER,
		DSL_PAT_SINGLE,
		DSL_PAT_DOUBLE
	} dsl_pattern_t;

	// Status from the drive core
	typedef struct packed {
		logic dc_bus_ok;
		logic drive_enabled;
		logic drive_fault;
		logic logic_supply_ok;
	} dsl_drive_stat_t;

	// Status from the network slave controller
	typedef struct packed {
		dsl_fb_state_t fb_state;
		logic          fw_download;
		logic [7:0]    al_change;
		logic          pdi_wdog_timeout;
		logic          config_error;
		logic          boot_error;
		logic          autonomous_change;
		logic          app_wdog_timeout;
		logic [1:0]    link_valid;
		logic [1:0]    link_traffic;
	} dsl_net_stat_t;

endpackage

// *** dsl_led_driver.sv ***
/*
 * Drive status lamp driver: maps drive and fieldbus status onto LEDs,
 * with an APB slave for alias, control, status and interrupts.
 * Assumes drive_stat and net_stat come from other clock domains and are
 * synchronised here, and that mclk runs at 100 MHz.
 */
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dsl_regs.svh"

module dsl_led_driver
	import dsl_pkg::*;
(
	// Clock and reset
	input  wire logic            mclk,
	input  wire logic            rst_n,
	// APB slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	// Status inputs
	input  wire dsl_drive_stat_t drive_stat,
	input  wire dsl_net_stat_t   net_stat,
	input  wire logic            net_alias_we,
	input  wire logic [15:0]     net_alias,
	input  wire logic [1:0]      auto_position,
	// Lamps
	output logic                 bridge_green,
	output logic                 bridge_red,
	output logic                 logic_supply_lamp,
	output logic [1:0]           port_link_traffic_lamp,
	output logic                 fieldbus_state_lamp,
	output logic                 error_lamp,
	output logic [15:0]          station_address,
	output logic                 irq
);

	localparam int SYNC_W = $bits(dsl_drive_stat_t) + $bits(dsl_net_stat_t);
	localparam logic [23:0] TICK_LAST = 24'(`DSL_TICK_CYC - 1);
	localparam logic [11:0] FLASH = 12'(`DSL_FLASH_MS);
	localparam logic [11:0] LONG_OFF = 12'(`DSL_LONG_OFF_MS);
	localparam logic [11:0] FLICK = 12'(`DSL_FLICKER_MS);

	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	dsl_drive_stat_t   drv;
	dsl_net_stat_t     net;
	logic [23:0]       tick_cnt_reg;
	logic              ms_tick;
	logic [31:0]       control_reg;
	logic [15:0]       alias_reg;
	logic [7:0]        irq_stat_reg;
	logic [7:0]        irq_mask_reg;
	logic [7:0]        events;
	logic [7:0]        ev_prev_reg;
	logic [7:0]        ev_rise;
	logic              apb_wr;
	logic              apb_rd;
	dsl_pattern_t      fb_pat;
	dsl_pattern_t      err_pat;
	dsl_pattern_t      fb_pat_reg;
	dsl_pattern_t      err_pat_reg;
	logic [11:0]       fb_ms_reg;
	logic [11:0]       err_ms_reg;
	logic [11:0]       trf_ms_reg;
	logic              fb_on;
	logic              err_on;
	logic              trf_on;

	// Two-stage synchroniser for drive_stat and net_stat
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= {drive_stat, net_stat};
			sync2_reg <= sync1_reg;
		end
	end
	assign {drv, net} = sync2_reg;

	// Millisecond tick divider
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			tick_cnt_reg <= '0;
			ms_tick <= 1'b0;
		end
		else
		begin
			ms_tick <= (tick_cnt_reg == TICK_LAST);
			if (tick_cnt_reg == TICK_LAST)
				tick_cnt_reg <= '0;
			else
				tick_cnt_reg <= tick_cnt_reg + 24'h000001;
		end
	end

	// Fieldbus lamp pattern selection
	always_comb
	begin
		unique case (net.fb_state)
			DSL_FB_OP:        fb_pat = DSL_PAT_ON;
			DSL_FB_PREOP:     fb_pat = DSL_PAT_BLINK;
			DSL_FB_SAFEOP:    fb_pat = DSL_PAT_SINGLE;
			DSL_FB_BOOT,
			DSL_FB_BOOTSTRAP: fb_pat = DSL_PAT_FLICKER;
			DSL_FB_INIT:      fb_pat = DSL_PAT_OFF;
			default:          fb_pat = DSL_PAT_OFF;
		endcase
		if (net.fw_download)
			fb_pat = DSL_PAT_FLICKER;
	end

	// Error lamp pattern by priority, watchdogs first
	always_comb
	begin
		if (net.pdi_wdog_timeout)
			err_pat = DSL_PAT_ON;
		else if (net.app_wdog_timeout)
			err_pat = DSL_PAT_DOUBLE;
		else if (net.boot_error && net.al_change == `DSL_AL_CHANGE_ERR)
			err_pat = DSL_PAT_FLICKER;
		else if (net.autonomous_change)
			err_pat = DSL_PAT_SINGLE;
		else if (net.config_error)
			err_pat = DSL_PAT_BLINK;
		else
			err_pat = DSL_PAT_OFF;
	end

	// Pattern phase timer: wraps at the period end
	function automatic logic [11:0] dsl_period(input dsl_pattern_t p);
		unique case (p)
			DSL_PAT_BLINK:   dsl_period = FLASH + FLASH;
			DSL_PAT_FLICKER: dsl_period = FLICK + FLICK;
			DSL_PAT_SINGLE:  dsl_period = FLASH + LONG_OFF;
			DSL_PAT_DOUBLE:  dsl_period = FLASH + FLASH + FLASH + LONG_OFF;
			default:         dsl_period = 12'h001;
		endcase
	endfunction

	// Lamp level for a pattern at a given millisecond of its period
	function automatic logic dsl_lit(input dsl_pattern_t p,
		input logic [11:0] ms);
		unique case (p)
			DSL_PAT_ON:      dsl_lit = 1'b1;
			DSL_PAT_BLINK:   dsl_lit = (ms < FLASH);
			DSL_PAT_FLICKER: dsl_lit = (ms < FLICK);
			DSL_PAT_SINGLE:  dsl_lit = (ms < FLASH);
			DSL_PAT_DOUBLE:  dsl_lit = (ms < FLASH) ||
				(ms >= FLASH + FLASH && ms < FLASH + FLASH + FLASH);
			default:         dsl_lit = 1'b0;
		endcase
	endfunction

	// Fieldbus phase counter restarts on a pattern change
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			fb_pat_reg <= DSL_PAT_OFF;
			fb_ms_reg <= '0;
		end
		else
		begin
			fb_pat_reg <= fb_pat;
			if (fb_pat != fb_pat_reg)
				fb_ms_reg <= '0;
			else if (ms_tick)
				fb_ms_reg <= (fb_ms_reg + 12'h001 >= dsl_period(fb_pat_reg))
					? 12'h000 : fb_ms_reg + 12'h001;
		end
	end

	// Error phase counter restarts on a pattern change
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			err_pat_reg <= DSL_PAT_OFF;
			err_ms_reg <= '0;
		end
		else
		begin
			err_pat_reg <= err_pat;
			if (err_pat != err_pat_reg)
				err_ms_reg <= '0;
			else if (ms_tick)
				err_ms_reg <= (err_ms_reg + 12'h001 >= dsl_period(err_pat_reg))
					? 12'h000 : err_ms_reg + 12'h001;
		end
	end

	// Traffic flicker phase runs free; it is shared by both ports
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			trf_ms_reg <= '0;
		else if (ms_tick)
			trf_ms_reg <= (trf_ms_reg + 12'h001 >= FLICK + FLICK)
				? 12'h000 : trf_ms_reg + 12'h001;
	end

	assign fb_on = dsl_lit(fb_pat_reg, fb_ms_reg);
	assign err_on = dsl_lit(err_pat_reg, err_ms_reg);
	assign trf_on = (trf_ms_reg < FLICK);

	// Drive lamps, registered; the test bit lights them all
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			bridge_green <= 1'b0;
			bridge_red <= 1'b0;
			logic_supply_lamp <= 1'b0;
		end
		else if (control_reg[`DSL_CTL_TEST_BIT])
		begin
			bridge_green <= 1'b1;
			bridge_red <= 1'b1;
			logic_supply_lamp <= 1'b1;
		end
		else
		begin
			bridge_red <= drv.drive_fault;
			bridge_green <= drv.dc_bus_ok && drv.drive_enabled
				&& !drv.drive_fault;
			logic_supply_lamp <= drv.logic_supply_ok;
		end
	end

	// Network lamps, registered; the test bit lights them all
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			port_link_traffic_lamp <= 2'h0;
			fieldbus_state_lamp <= 1'b0;
			error_lamp <= 1'b0;
		end
		else if (control_reg[`DSL_CTL_TEST_BIT])
		begin
			port_link_traffic_lamp <= 2'h3;
			fieldbus_state_lamp <= 1'b1;
			error_lamp <= 1'b1;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
				port_link_traffic_lamp[i] <= net.link_valid[i] &&
					(!net.link_traffic[i] || trf_on);
			fieldbus_state_lamp <= fb_on;
			error_lamp <= err_on;
		end
	end

	// Station address: alias from network or software, else position
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			alias_reg <= `DSL_ALIAS_RESET;
		else if (apb_wr && paddr == `DSL_ALIAS_ADDR)
			alias_reg <= pwdata[15:0];
		else if (net_alias_we)
			alias_reg <= net_alias;
	end

	// Registered station address: a zero alias falls back to position
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			station_address <= 16'h0000;
		else if (alias_reg != 16'h0000)
			station_address <= alias_reg;
		else
			station_address <= {14'h0000, auto_position};
	end

	// Interrupt events: rising edges of fault and error conditions
	assign events = {1'b0, drv.drive_fault, !drv.logic_supply_ok,
		net.pdi_wdog_timeout, net.app_wdog_timeout, net.config_error,
		net.boot_error, net.autonomous_change};

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;

	// Previous event levels; the synchroniser resets the supply flag low,
	// so the supply-lost bit starts high and no false edge follows reset
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			ev_prev_reg <= `DSL_EV_PREV_RESET;
		else
			ev_prev_reg <= events;
	end

	assign ev_rise = events & ~ev_prev_reg;

	// Sticky status: a read clears only the bits it reported, so an event
	// landing between setup and access is kept; a new event wins the clear
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_stat_reg <= '0;
		else if (apb_rd && paddr == `DSL_IRQ_STAT_ADDR)
			irq_stat_reg <= (irq_stat_reg & ~prdata[7:0]) | ev_rise;
		else
			irq_stat_reg <= irq_stat_reg | ev_rise;
	end

	// Interrupt mask, same layout as the status
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_mask_reg <= `DSL_MASK_RESET;
		else if (apb_wr && paddr == `DSL_IRQ_MASK_ADDR)
			irq_mask_reg <= pwdata[7:0];
	end

	// Level interrupt, one cycle behind the status
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_reg & irq_mask_reg);
	end

	// Control register
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			control_reg <= `DSL_CONTROL_RESET;
		else if (apb_wr && paddr == `DSL_CONTROL_ADDR)
			control_reg <= pwdata & 32'h0000_0003;
	end

	// APB: read data is picked at the setup edge and pready rises for the
	// first access cycle, so every transfer ends with no wait state
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel && !penable)
			begin
				unique case (paddr)
					`DSL_STATUS_ADDR: prdata <= {16'h0000,
						5'h00, net.fb_state, 2'h0, err_pat_reg, fb_pat_reg};
					`DSL_CONTROL_ADDR:  prdata <= control_reg;
					`DSL_IRQ_STAT_ADDR: prdata <= {24'h0, irq_stat_reg};
					`DSL_IRQ_MASK_ADDR: prdata <= {24'h0, irq_mask_reg};
					`DSL_ALIAS_ADDR:    prdata <= {16'h0, alias_reg};
					`DSL_LAMPS_ADDR:    prdata <= {24'h0, bridge_green,
						bridge_red, logic_supply_lamp, port_link_traffic_lamp,
						fieldbus_state_lamp, error_lamp, 1'b0};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// *** dsl_led_checker.sv ***
/* Lamp assertions for dsl_led_driver.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module dsl_led_checker
	import dsl_pkg::*;
(
	// Clock and reset
	input wire logic            mclk,
	input wire logic            rst_n,
	// Status in, lamps out
	input wire dsl_drive_stat_t drive_stat,
	input wire dsl_net_stat_t   net_stat,
	input wire logic            bridge_green,
	input wire logic            bridge_red,
	input wire logic            logic_supply_lamp,
	input wire logic [1:0]      port_link_traffic_lamp,
	input wire logic            fieldbus_state_lamp,
	input wire logic            error_lamp
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Lamps follow inputs held for six cycles; the PDI error lamp lights within six cycles of a rise
	green_on_a: assert property (
		(rst_n && drive_stat[3:1] == 3'h6) [*6] |-> bridge_green)
		else $error("bridge green missing");
	red_wins_a: assert property (
		(rst_n && drive_stat[1]) [*6] |-> bridge_red && !bridge_green)
		else $error("bridge red wrong");
	supply_off_a: assert property (
		(rst_n && !drive_stat[0]) [*6] |-> !logic_supply_lamp)
		else $error("supply lamp lit");
	link_idle_a: assert property (
		(rst_n && net_stat[2] && !net_stat[0]) [*6]
		|-> port_link_traffic_lamp[0]) else $error("idle link dark");
	link_dead_a: assert property (
		(rst_n && !net_stat[3]) [*6] |-> !port_link_traffic_lamp[1])
		else $error("dead link lit");
	fb_op_a: assert property (
		(rst_n && net_stat.fb_state == DSL_FB_OP && !net_stat.fw_download)
		[*6] |-> fieldbus_state_lamp) else $error("op lamp dark");
	fb_init_a: assert property (
		(rst_n && net_stat.fb_state == DSL_FB_INIT && !net_stat.fw_download)
		[*6] |-> !fieldbus_state_lamp) else $error("init lamp lit");
	pdi_red_a: assert property (
		$rose(net_stat.pdi_wdog_timeout) |-> ##[1:6] error_lamp)
		else $error("pdi timeout lamp dark");
	err_off_a: assert property (
		(rst_n && net_stat[8:4] == 5'h0) [*6] |-> !error_lamp)
		else $error("error lamp lit");
endmodule

bind dsl_led_driver dsl_led_checker u_chk (.mclk, .rst_n, .drive_stat,
	.net_stat, .bridge_green, .bridge_red, .logic_supply_lamp,
	.port_link_traffic_lamp, .fieldbus_state_lamp, .error_lamp);
`default_nettype wire

// *** dsl_lamp_watch.sv ***
/* Operator model: watches one lamp and counts its changes.
   Assumes the lamp is a registered level on mclk. */
`timescale 1ns/1ps
`default_nettype none
module dsl_lamp_watch
(
	// Clock and clear
	input  wire logic mclk,
	input  wire logic clr,
	// Lamp seen, changes counted
	input  wire logic lamp,
	output var int    flips
);
	logic last;

	// Count every change since the last clear
	always_ff @(posedge mclk)
	begin
		last <= lamp;
		flips <= clr ? 0 : flips + int'(lamp != last);
	end
endmodule
`default_nettype wire

// *** test_drive_status_led_driver.sv ***
/* Self-checking bench for dsl_led_driver.
   Assumes the designer's pattern and register codes. */
`timescale 1ns/1ps
`default_nettype none
module test_drive_status_led_driver
	import dsl_pkg::*;
;
	logic            mclk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic            net_alias_we, bridge_green, bridge_red, irq, er, clr;
	logic            logic_supply_lamp, fieldbus_state_lamp, error_lamp;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, prdata, rd;
	logic [15:0]     net_alias, station_address;
	logic [1:0]      auto_position, port_link_traffic_lamp;
	dsl_drive_stat_t drive_stat;
	dsl_net_stat_t   net_stat;
	int              fail_count = 0;
	int              comparisons = 0;
	int              flips;

	// Design and operator model
	dsl_led_driver DUT (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .drive_stat, .net_stat,
		.net_alias_we, .net_alias, .auto_position, .bridge_green,
		.bridge_red, .logic_supply_lamp, .port_link_traffic_lamp,
		.fieldbus_state_lamp, .error_lamp, .station_address, .irq);
	dsl_lamp_watch u_op (.mclk, .clr, .lamp(fieldbus_state_lamp), .flips);

	// 100 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task settle;
		repeat (8) @(posedge mclk);
	endtask

	// One APB transfer, then one idle cycle; only the hang guard ends a wait
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task t_irq;
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h0);
		drive_stat.drive_fault <= 1'b1;
		settle();
		chk(irq, 1'b0);
		apb(1'b1, 12'h00C, 32'h40);
		settle();
		chk(irq, 1'b1);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h40);
		settle();
		chk(irq, 1'b0);
	endtask

	task t_lamps;
		logic [3:0] dv[4] = '{4'hD, 4'hF, 4'h8, 4'h1};
		logic [2:0] lv[4] = '{3'h5, 3'h3, 3'h0, 3'h1};
		for (int i = 0; i < 4; i++)
		begin
			drive_stat <= dv[i];
			settle();
			chk({bridge_green, bridge_red, logic_supply_lamp}, lv[i]);
		end
		net_stat[3:0] <= 4'h4;
		settle();
		chk(port_link_traffic_lamp, 2'h1);
		net_stat[3:0] <= 4'h8;
		settle();
		chk(port_link_traffic_lamp, 2'h2);
		net_stat[3:0] <= 4'h7;
		settle();
		chk(port_link_traffic_lamp, 2'h1);
		net_stat[3:0] <= 4'hB;
		settle();
		chk(port_link_traffic_lamp, 2'h2);
	endtask

	task t_fieldbus;
		logic [2:0] fp[6] = '{3'h3, 3'h0, 3'h2, 3'h3, 3'h4, 3'h1};
		for (int i = 0; i < 6; i++)
		begin
			net_stat.fb_state <= dsl_fb_state_t'(i[2:0]);
			settle();
			apb(1'b0, 12'h000, 32'h0);
			chk({rd[10:8], rd[2:0]}, {i[2:0], fp[i]});
			chk(fieldbus_state_lamp, fp[i] != 3'h0);
		end
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		repeat (40) @(posedge mclk);
		chk(flips, 32'h0);
		net_stat.fb_state <= DSL_FB_INIT;
		net_stat.fw_download <= 1'b1;
		settle();
		apb(1'b0, 12'h000, 32'h0);
		chk(rd[2:0], 3'h3);
	endtask

	task t_errors;
		logic [4:0] ev[8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1F,
			5'h0B, 5'h0A};
		logic [2:0] ep[8] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1, 3'h5,
			3'h4};
		net_stat.al_change <= 8'h01;
		for (int i = 0; i < 8; i++)
		begin
			net_stat[8:4] <= ev[i];
			settle();
			apb(1'b0, 12'h000, 32'h0);
			chk(rd[5:3], ep[i]);
			chk(error_lamp, 1'b1);
		end
		net_stat[8:4] <= 5'h0;
		settle();
		chk(error_lamp, 1'b0);
	endtask

	task t_regs;
		auto_position <= 2'h2;
		settle();
		chk(station_address, 16'h0002);
		apb(1'b1, 12'h010, 32'h1234);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h1234);
		chk(station_address, 16'h1234);
		net_alias <= 16'h0055;
		net_alias_we <= 1'b1;
		@(posedge mclk);
		net_alias_we <= 1'b0;
		settle();
		chk(station_address, 16'h0055);
		apb(1'b0, 12'h020, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		net_stat.config_error <= 1'b1;
		apb(1'b1, 12'h004, 32'h2);
		settle();
		apb(1'b0, 12'h014, 32'h0);
		chk(rd, 32'hFE);
		apb(1'b1, 12'h004, 32'h0);
		settle();
		apb(1'b0, 12'h014, 32'h0);
		chk(rd, 32'h36);
	endtask

	task end_of_test;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Reset, then scenarios in turn
	initial
	begin
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, net_alias_we, net_alias,
			auto_position, drive_stat, net_stat, clr} = '0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_irq();
		t_lamps();
		t_fieldbus();
		t_errors();
		t_regs();
		end_of_test();
	end

	// Hang guard
	initial
	begin
		#100us;
		fail_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
